/* File: hw/sau_defines.svh */
// register offsets, field positions, reset values and sizes for the attribution unit
`ifndef SAU_DEFINES_SVH
`define SAU_DEFINES_SVH

`define SAU_ADDR_CTRL 32'he000edd0
`define SAU_ADDR_TYPE 32'he000edd4
`define SAU_ADDR_RNR 32'he000edd8
`define SAU_ADDR_RBAR 32'he000eddc
`define SAU_ADDR_RLAR 32'he000ede0

`define ATTRIBUTION_CONTROL_EN_BIT 0
`define ATTRIBUTION_CONTROL_ALL_NONSECURE_OVERRIDE_BIT 1
`define ATTRIBUTION_CONTROL_RESET 2'h0
`define REGION_LIMIT_EN_BIT 0
`define REGION_LIMIT_NSC_BIT 1
`define SAU_ADDR_LSB 5
`define SAU_LOW_ONES 5'h1f
`define SAU_REGIONS 8
`define SAU_IDX_W 3

`endif

/* File: hw/sau_pkg.sv */
// types shared by the attribution unit files
package sau_pkg;
  typedef enum logic [1:0] {
    SAU_ATTR_S = 2'h0,
    SAU_ATTR_NS = 2'h1,
    SAU_ATTR_NSC = 2'h2
  } sau_attr_t;

  typedef struct packed {
    logic [26:0] base;
    logic [26:0] limit;
    logic callable_from_nonsecure;
    logic en;
  } sau_region_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic ns_state;
  } sau_req_t;

  typedef struct packed {
    sau_attr_t attr;
    logic secure_fault;
    logic ns_request;
  } sau_resp_t;
endpackage

/* File: hw/sau_region_mem.sv */
// region table storage, registered read of the selected region
`timescale 1ns/1ps
`default_nettype none
`include "sau_defines.svh"
module sau_region_mem (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic wr_base_in,
  input wire logic wr_limit_in,
  input wire logic [`SAU_IDX_W-1:0] idx_in,
  input wire logic [26:0] wdata_in,
  input wire logic wnsc_in,
  input wire logic wen_in,
  output var sau_pkg::sau_region_t rd_out,
  output var sau_pkg::sau_region_t all_out [`SAU_REGIONS]
);
  sau_pkg::sau_region_t mem_r [`SAU_REGIONS];
  sau_pkg::sau_region_t mem_nxt [`SAU_REGIONS];
  sau_pkg::sau_region_t rd_r;

  always_comb begin
    for (int i = 0; i < `SAU_REGIONS; i++) begin
      mem_nxt[i] = mem_r[i];
      if (idx_in == i[`SAU_IDX_W-1:0]) begin
        if (wr_base_in) begin
          mem_nxt[i].base = wdata_in;
        end
        if (wr_limit_in) begin
          mem_nxt[i].limit = wdata_in;
          mem_nxt[i].callable_from_nonsecure = wnsc_in;
          mem_nxt[i].en = wen_in;
        end
      end
    end
  end

  // region enables cleared so stale tables never attribute
  always_ff @(posedge mclk_in) begin
    for (int i = 0; i < `SAU_REGIONS; i++) begin
      if (sys_rst_in) begin
        mem_r[i] <= '0;
      end else begin
        mem_r[i] <= mem_nxt[i];
      end
    end
    if (sys_rst_in) begin
      rd_r <= '0;
    end else begin
      rd_r <= mem_nxt[idx_in];
    end
  end

  assign rd_out = rd_r;
  assign all_out = mem_r;
endmodule // sau_region_mem
`default_nettype wire

/* File: hw/sau_match.sv */
// per-address region lookup over the implemented regions
`timescale 1ns/1ps
`default_nettype none
`include "sau_defines.svh"
module sau_match (
  input wire logic [31:0] addr_in,
  input wire logic [3:0] count_in,
  input wire sau_pkg::sau_region_t regions_in [`SAU_REGIONS],
  output logic hit_out,
  output logic nsc_out
);
  logic [`SAU_REGIONS-1:0] hit;
  logic [`SAU_REGIONS-1:0] callable_from_nonsecure;

  genvar g;
  generate
    for (g = 0; g < `SAU_REGIONS; g++) begin : g_reg
      // base inclusive, limit with low bits all ones
      assign hit[g] = (g < count_in) && regions_in[g].en &&
        (addr_in >= {regions_in[g].base, 5'h00}) &&
        (addr_in <= {regions_in[g].limit, `SAU_LOW_ONES});
      assign callable_from_nonsecure[g] = hit[g] && regions_in[g].callable_from_nonsecure;
    end
  endgenerate

  assign hit_out = |hit;
  assign nsc_out = |callable_from_nonsecure;
endmodule // sau_match
`default_nettype wire

/* File: hw/sau_top.sv */
// security attribution unit: registers, attribution of fetch and data addresses
//
// Contract
// - every presented address is attributed a security state
// - region count is a parameter, only 0, 4 or 8
// - unit comes out of reset disabled
// - no regions while enabled, or disabled with bit 1 clear, without external source: all Secure
// - in all-Secure case a switch to Non-secure faults
// - register writes act only from Secure state
// - Non-secure register access reads zero, writes ignored
// - every register is 32 bits wide
// - reserved bits read zero
// - control bit 0 is the global enable
// - control bit 1 picks Non-secure or Secure while disabled
// - type register reports the number of regions
// - region-select low 8 bits choose region for base and limit
// - limit keeps bits 31:5, low five bits match as ones but read back as zeros and the two flag bits
// - limit bit 1 marks region callable from Non-secure
// - limit bit 0 enables the region
// - attribute returned for both fetch and data addresses
// - callable attribute decides Non-secure entry into Secure code
// - Non-secure data access to Secure address raises secure fault
// - Secure data access to Non-secure address goes out marked Non-secure
// - enabled unit: uncovered addresses are Secure
// - enabled region: Non-secure, or Secure callable when callable bit set
`timescale 1ns/1ps
`default_nettype none
`include "sau_defines.svh"
module sau_top #(
  parameter int unsigned NUM_REGIONS = 8
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_ns_in,
  output logic [31:0] reg_rdata_out,
  input wire sau_pkg::sau_req_t ifetch_in,
  input wire sau_pkg::sau_req_t data_in,
  input wire logic ns_switch_in,
  output var sau_pkg::sau_resp_t ifetch_out,
  output var sau_pkg::sau_resp_t data_out,
  output logic ns_entry_ok_out,
  output logic switch_fault_out
);
  // sizes other than 4 or 8 elaborate with no regions
  localparam logic [3:0] COUNT = (NUM_REGIONS == 8) ? 4'h8 :
    (NUM_REGIONS == 4) ? 4'h4 : 4'h0;

  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic [7:0] rnr_r;
  logic [7:0] rnr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic sel_ctrl_r;
  logic sel_ctrl_nxt;
  logic [3:0] sel_r;
  logic [3:0] sel_nxt;
  sau_pkg::sau_resp_t if_r;
  sau_pkg::sau_resp_t if_nxt;
  sau_pkg::sau_resp_t d_r;
  sau_pkg::sau_resp_t d_nxt;
  logic entry_r;
  logic entry_nxt;
  logic sfault_r;
  logic sfault_nxt;
  logic sec_wr;
  logic wr_base;
  logic wr_limit;
  logic if_hit;
  logic if_nsc;
  logic d_hit;
  logic d_nsc;
  sau_pkg::sau_region_t rd_region;
  sau_pkg::sau_region_t regions [`SAU_REGIONS];

  function automatic sau_pkg::sau_attr_t attr_of(input logic hit, input logic callable_from_nonsecure,
                                                 input logic [1:0] ctrl,
                                                 input logic [3:0] cnt);
    if (!ctrl[`ATTRIBUTION_CONTROL_EN_BIT] || cnt == 4'h0) begin
      // disabled: override bit chooses, no external source here
      attr_of = ctrl[`ATTRIBUTION_CONTROL_ALL_NONSECURE_OVERRIDE_BIT] && !ctrl[`ATTRIBUTION_CONTROL_EN_BIT] ?
        sau_pkg::SAU_ATTR_NS : sau_pkg::SAU_ATTR_S;
    end else if (!hit) begin
      attr_of = sau_pkg::SAU_ATTR_S;
    end else if (callable_from_nonsecure) begin
      attr_of = sau_pkg::SAU_ATTR_NSC;
    end else begin
      attr_of = sau_pkg::SAU_ATTR_NS;
    end
  endfunction

  // same decode as the disabled branch above, so fault and attribute never disagree
  function automatic logic all_secure(input logic [1:0] ctrl, input logic [3:0] cnt);
    all_secure = (!ctrl[`ATTRIBUTION_CONTROL_EN_BIT] || cnt == 4'h0) &&
      !(ctrl[`ATTRIBUTION_CONTROL_ALL_NONSECURE_OVERRIDE_BIT] && !ctrl[`ATTRIBUTION_CONTROL_EN_BIT]);
  endfunction

  // Non-secure accesses never write
  assign sec_wr = reg_wr_in && !reg_ns_in;
  // out-of-range region index ignores base and limit writes
  assign wr_base = sec_wr && reg_addr_in == `SAU_ADDR_RBAR && {1'b0, rnr_r} < {5'h00, COUNT};
  assign wr_limit = sec_wr && reg_addr_in == `SAU_ADDR_RLAR && {1'b0, rnr_r} < {5'h00, COUNT};

  sau_region_mem u_mem (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .wr_base_in(wr_base),
    .wr_limit_in(wr_limit),
    .idx_in(rnr_r[`SAU_IDX_W-1:0]),
    .wdata_in(reg_wdata_in[31:`SAU_ADDR_LSB]),
    .wnsc_in(reg_wdata_in[`REGION_LIMIT_NSC_BIT]),
    .wen_in(reg_wdata_in[`REGION_LIMIT_EN_BIT]),
    .rd_out(rd_region),
    .all_out(regions)
  );

  sau_match u_if_match (
    .addr_in(ifetch_in.addr),
    .count_in(COUNT),
    .regions_in(regions),
    .hit_out(if_hit),
    .nsc_out(if_nsc)
  );

  sau_match u_d_match (
    .addr_in(data_in.addr),
    .count_in(COUNT),
    .regions_in(regions),
    .hit_out(d_hit),
    .nsc_out(d_nsc)
  );

  // register state
  always_comb begin
    ctrl_nxt = ctrl_r;
    rnr_nxt = rnr_r;
    if (sec_wr && reg_addr_in == `SAU_ADDR_CTRL) begin
      ctrl_nxt = reg_wdata_in[1:0];
    end
    if (sec_wr && reg_addr_in == `SAU_ADDR_RNR) begin
      rnr_nxt = reg_wdata_in[7:0];
    end
  end

  // read path: region reads come from the table's own register next cycle
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    sel_ctrl_nxt = 1'b0;
    sel_nxt = 4'h0;
    if (reg_rd_in && !reg_ns_in) begin
      unique case (reg_addr_in)
        `SAU_ADDR_CTRL: rdata_nxt = {30'h0, ctrl_r};
        `SAU_ADDR_TYPE: rdata_nxt = {28'h0, COUNT};
        `SAU_ADDR_RNR: rdata_nxt = {24'h0, rnr_r};
        `SAU_ADDR_RBAR: sel_nxt = 4'h1;
        `SAU_ADDR_RLAR: sel_nxt = 4'h2;
        default: rdata_nxt = 32'h0000_0000;
      endcase
      if ({1'b0, rnr_r} >= {5'h00, COUNT}) begin
        sel_nxt = 4'h0;
      end
    end
    sel_ctrl_nxt = |sel_nxt;
  end

  always_comb begin
    reg_rdata_out = rdata_r;
    if (sel_ctrl_r && sel_r[0]) begin
      reg_rdata_out = {rd_region.base, 5'h00};
    end else if (sel_ctrl_r && sel_r[1]) begin
      reg_rdata_out = {rd_region.limit, 3'h0, rd_region.callable_from_nonsecure, rd_region.en};
    end
  end

  // attribution of both address streams
  always_comb begin
    if_nxt = '0;
    d_nxt = '0;
    if_nxt.attr = attr_of(if_hit, if_nsc, ctrl_r, COUNT);
    d_nxt.attr = attr_of(d_hit, d_nsc, ctrl_r, COUNT);
    // Non-secure fetch from Secure or callable code is a fault
    if_nxt.secure_fault = ifetch_in.valid && ifetch_in.ns_state &&
      if_nxt.attr != sau_pkg::SAU_ATTR_NS;
    if_nxt.ns_request = ifetch_in.valid && if_nxt.attr == sau_pkg::SAU_ATTR_NS;
    d_nxt.secure_fault = data_in.valid && data_in.ns_state &&
      d_nxt.attr != sau_pkg::SAU_ATTR_NS;
    d_nxt.ns_request = data_in.valid && d_nxt.attr == sau_pkg::SAU_ATTR_NS;
    // entry allowed only at a callable address
    entry_nxt = ifetch_in.valid && ifetch_in.ns_state &&
      if_nxt.attr == sau_pkg::SAU_ATTR_NSC;
    // everything Secure: no Non-secure state to switch into
    sfault_nxt = ns_switch_in && all_secure(ctrl_r, COUNT);
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctrl_r <= `ATTRIBUTION_CONTROL_RESET;
      rnr_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
      sel_ctrl_r <= 1'b0;
      sel_r <= 4'h0;
      if_r <= '0;
      d_r <= '0;
      entry_r <= 1'b0;
      sfault_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      rnr_r <= rnr_nxt;
      rdata_r <= rdata_nxt;
      sel_ctrl_r <= sel_ctrl_nxt;
      sel_r <= sel_nxt;
      if_r <= if_nxt;
      d_r <= d_nxt;
      entry_r <= entry_nxt;
      sfault_r <= sfault_nxt;
    end
  end

  assign ifetch_out = if_r;
  assign data_out = d_r;
  assign ns_entry_ok_out = entry_r;
  assign switch_fault_out = sfault_r;
endmodule // sau_top
`default_nettype wire

/* File: bench/sau_top_asserts.sv */
// port checker for the attribution unit
`timescale 1ns/1ps
`default_nettype none
`include "sau_defines.svh"
module sau_top_asserts #(
  parameter int unsigned NUM_REGIONS = 8
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_ns_in,
  input wire logic [31:0] reg_rdata_out,
  input wire sau_pkg::sau_req_t ifetch_in,
  input wire sau_pkg::sau_req_t data_in,
  input wire logic ns_switch_in,
  input wire sau_pkg::sau_resp_t ifetch_out,
  input wire sau_pkg::sau_resp_t data_out,
  input wire logic ns_entry_ok_out,
  input wire logic switch_fault_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);
  property p_rst;
    $past(sys_rst_in) |-> reg_rdata_out == 32'h0 && !switch_fault_out && data_out == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("not quiet after reset");
  property p_nsrd;
    reg_rd_in && reg_ns_in |=> reg_rdata_out == 32'h0;
  endproperty
  a_nsrd: assert property (p_nsrd) else $error("nonsecure read not zero");
  property p_type;
    reg_rd_in && !reg_ns_in && reg_addr_in == `SAU_ADDR_TYPE |=> reg_rdata_out == NUM_REGIONS;
  endproperty
  a_type: assert property (p_type) else $error("bad region count");
  property p_fault;
    data_in.valid && data_in.ns_state |=>
      data_out.secure_fault == (data_out.attr != sau_pkg::SAU_ATTR_NS);
  endproperty
  a_fault: assert property (p_fault) else $error("secure fault wrong");
  property p_sfree;
    data_in.valid && !data_in.ns_state |=> !data_out.secure_fault;
  endproperty
  a_sfree: assert property (p_sfree) else $error("fault on secure access");
  property p_nsreq;
    data_in.valid && !data_in.ns_state |=>
      data_out.ns_request == (data_out.attr == sau_pkg::SAU_ATTR_NS);
  endproperty
  a_nsreq: assert property (p_nsreq) else $error("request marking wrong");
  property p_entry;
    ifetch_in.valid && ifetch_in.ns_state |=>
      ns_entry_ok_out == (ifetch_out.attr == sau_pkg::SAU_ATTR_NSC);
  endproperty
  a_entry: assert property (p_entry) else $error("entry flag wrong");
  property p_sw;
    switch_fault_out |-> $past(ns_switch_in);
  endproperty
  a_sw: assert property (p_sw) else $error("switch fault without cause");
endmodule // sau_top_asserts
bind sau_top sau_top_asserts #(.NUM_REGIONS(NUM_REGIONS)) u_chk (.mclk_in(mclk_in),
  .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_ns_in(reg_ns_in), .reg_rdata_out(reg_rdata_out), .ifetch_in(ifetch_in),
  .data_in(data_in), .ns_switch_in(ns_switch_in), .ifetch_out(ifetch_out),
  .data_out(data_out), .ns_entry_ok_out(ns_entry_ok_out),
  .switch_fault_out(switch_fault_out));
`default_nettype wire

/* File: bench/sau_cpu_model.sv */
// processor side model: one fetch or data request per go pulse
`timescale 1ns/1ps
`default_nettype none
module sau_cpu_model (
  input wire logic mclk_in,
  input wire logic go_in,
  input wire logic fetch_in,
  input wire logic [31:0] addr_in,
  input wire logic ns_in,
  output var sau_pkg::sau_req_t ifetch_out,
  output var sau_pkg::sau_req_t data_out
);
  // idle address is scrambled so nothing leans on a stale value
  always_ff @(posedge mclk_in) begin
    ifetch_out <= '{go_in & fetch_in, go_in ? addr_in : ~addr_in, ns_in};
    data_out <= '{go_in & ~fetch_in, go_in ? addr_in : ~addr_in, ns_in};
  end
endmodule // sau_cpu_model
`default_nettype wire

/* File: bench/sau_top_tb_top.sv */
// testbench for the attribution unit
`timescale 1ns/1ps
`default_nettype none
`include "sau_defines.svh"
module sau_top_tb_top;
  logic mclk_in = 1'b0;
  logic rst = 1'b1, wr = 1'b0, rd = 1'b0, rns = 1'b0, sw = 1'b0, go = 1'b0, fch = 1'b0, cns = 1'b0;
  logic [31:0] ra = 32'h0, wd = 32'h0, ca = 32'h0, rdata;
  sau_pkg::sau_req_t ireq, dreq;
  sau_pkg::sau_resp_t iresp, dresp;
  logic ok, swf;
  int err_total = 0, checks_done = 0, cyc = 0;
  sau_top #(.NUM_REGIONS(8)) u_sau_top (.mclk_in(mclk_in), .sys_rst_in(rst), .reg_addr_in(ra),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_ns_in(rns), .reg_rdata_out(rdata),
    .ifetch_in(ireq), .data_in(dreq), .ns_switch_in(sw), .ifetch_out(iresp), .data_out(dresp),
    .ns_entry_ok_out(ok), .switch_fault_out(swf));
  sau_cpu_model u_sau_cpu_model (.mclk_in(mclk_in), .go_in(go), .fetch_in(fch), .addr_in(ca),
    .ns_in(cns), .ifetch_out(ireq), .data_out(dreq));
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrr(input logic [31:0] a, d, input logic n = 1'b0);
    ra <= a;
    wd <= d;
    rns <= n;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rdc(input logic [31:0] a, exp, input logic n = 1'b0);
    ra <= a;
    rns <= n;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 chk(rdata, exp, "rdata");
    @(posedge mclk_in);
  endtask
  // expected packs {attr, fault, ns_request, entry_ok}
  task automatic acc(input logic f, input logic [31:0] a, input logic n, input logic [4:0] e);
    go <= 1'b1;
    fch <= f;
    ca <= a;
    cns <= n;
    @(posedge mclk_in);
    go <= 1'b0;
    @(posedge mclk_in);
    #1 chk({27'h0, f ? iresp : dresp, ok}, {27'h0, e}, "attribute");
    @(posedge mclk_in);
  endtask
  task automatic swc(input logic e);
    sw <= 1'b1;
    @(posedge mclk_in);
    sw <= 1'b0;
    #1 chk({31'h0, swf}, {31'h0, e}, "switch_fault");
    @(posedge mclk_in);
  endtask
  task automatic t_reset;
    rdc(`SAU_ADDR_CTRL, 32'h0);
    rdc(`SAU_ADDR_TYPE, 32'h8);
    acc(1'b0, 32'h1000_0000, 1'b1, 5'h04);
    swc(1'b1);
  endtask
  task automatic t_regions;
    wrr(`SAU_ADDR_RNR, 32'h3);
    wrr(`SAU_ADDR_RBAR, 32'h1000_0000);
    wrr(`SAU_ADDR_RLAR, 32'h1000_0ffd);
    rdc(`SAU_ADDR_RLAR, 32'h1000_0fe1);
    wrr(`SAU_ADDR_RNR, 32'h5);
    wrr(`SAU_ADDR_RBAR, 32'h2000_005f);
    rdc(`SAU_ADDR_RBAR, 32'h2000_0040);
    wrr(`SAU_ADDR_RLAR, 32'h2000_0063);
    rdc(`SAU_ADDR_RLAR, 32'h2000_0063);
    wrr(`SAU_ADDR_CTRL, 32'h1);
    rdc(`SAU_ADDR_CTRL, 32'h1);
    acc(1'b0, 32'h1000_0000, 1'b0, 5'h0a);
    acc(1'b0, 32'h1000_0fff, 1'b0, 5'h0a);
    acc(1'b1, 32'h1000_0800, 1'b0, 5'h0a);
    acc(1'b0, 32'h1000_1000, 1'b1, 5'h04);
    acc(1'b0, 32'h0fff_ffff, 1'b1, 5'h04);
    acc(1'b1, 32'h2000_007f, 1'b1, 5'h15);
    acc(1'b0, 32'h2000_003f, 1'b1, 5'h04);
    swc(1'b0);
    wrr(`SAU_ADDR_RNR, 32'h3);
    wrr(`SAU_ADDR_RLAR, 32'h1000_0fe0);
    acc(1'b0, 32'h1000_0000, 1'b0, 5'h00);
  endtask
  task automatic t_nsacc;
    wrr(`SAU_ADDR_CTRL, 32'h0, 1'b1);
    rdc(`SAU_ADDR_CTRL, 32'h0, 1'b1);
    rdc(`SAU_ADDR_CTRL, 32'h1);
    rdc(32'he000ede4, 32'h0);
    wrr(`SAU_ADDR_RNR, 32'hffff_ff05);
    rdc(`SAU_ADDR_RNR, 32'h5);
  endtask
  task automatic t_all_nonsecure_override;
    wrr(`SAU_ADDR_CTRL, 32'hffff_fffe);
    rdc(`SAU_ADDR_CTRL, 32'h2);
    acc(1'b0, 32'h1000_1000, 1'b0, 5'h0a);
    swc(1'b0);
  endtask
  task automatic test_done;
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ceiling well above the roughly 90 cycles the run needs
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge mclk_in);
    rst <= 1'b0;
    @(posedge mclk_in);
    t_reset();
    t_regions();
    t_nsacc();
    t_all_nonsecure_override();
    test_done();
  end
endmodule // sau_top_tb_top
`default_nettype wire
